//--- logic/pdmc_pkg.sv
package pdmc_pkg;
  localparam int          PDMC_AXI_AW       = 16;
  localparam logic [15:0] PDMC_SYSCTL_ADDR  = 16'hffc4;
  localparam logic [15:0] PDMC_STATUS_ADDR  = 16'hffc8;
  localparam logic [7:0]  PDMC_SYSCTL_RESET = 8'h09;
  localparam int          PDMC_STANDBY_SELECT_BIT_BIT     = 7;
  localparam int          PDMC_STS_MSB      = 6;
  localparam int          PDMC_STS_LSB      = 4;
  localparam int          PDMC_FIXED_BIT    = 3;
  localparam int          PDMC_LOW_MSB      = 2;
  localparam int          PDMC_BASE_STATES  = 8192;
  localparam int          PDMC_CNT_W        = 18;
  localparam int          PDMC_PIN_W        = 6;
  localparam logic [5:0]  PDMC_PIN_IDLE     = 6'h3f;
  localparam logic [1:0]  PDMC_RESP_OKAY    = 2'h0;
  localparam logic [1:0]  PDMC_RESP_DECERR  = 2'h3;

  typedef enum logic [5:0] {
    PDMC_RUN    = 6'h01,
    PDMC_SLEEP  = 6'h02,
    PDMC_SWSTBY = 6'h04,
    PDMC_SETTLE = 6'h08,
    PDMC_HWSTBY = 6'h10,
    PDMC_CLEAR  = 6'h20
  } pdmc_state_t;

  // Codes with the top bit set all give the longest wait
  function automatic logic [PDMC_CNT_W-1:0] pdmc_settle_cycles(input logic [2:0] sel,
                                                                input int         base);
    logic [PDMC_CNT_W-1:0] b;
    b = PDMC_CNT_W'(base);
    if (sel[2])
    begin
      return b << 4;
    end
    return b << sel[1:0];
  endfunction : pdmc_settle_cycles
endpackage : pdmc_pkg

//--- logic/pdmc_pin_sync.sv
`timescale 1ns/1ps
module pdmc_pin_sync
  import pdmc_pkg::*;
#(
  parameter int              W    = PDMC_PIN_W,
  parameter logic [W-1:0]    INIT = PDMC_PIN_IDLE
)
(
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      meta   <= INIT;
      sync_o <= INIT;
    end
    else
    begin
      meta   <= pin_i;
      sync_o <= meta;
    end
  end
endmodule : pdmc_pin_sync

//--- logic/pdmc_settle_counter.sv
`timescale 1ns/1ps
module pdmc_settle_counter
  import pdmc_pkg::*;
#(
  parameter int BASE_STATES = PDMC_BASE_STATES
)
(
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       start_i,
  input  wire logic       abort_i,
  input  wire logic [2:0] sel_i,
  output logic            busy_o,
  output logic            done_o
);
  logic [PDMC_CNT_W-1:0] cnt;
  logic [PDMC_CNT_W-1:0] last;

  // One count per state, first state included
  assign done_o = busy_o && (cnt == last);

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || abort_i)
    begin
      busy_o <= 1'b0;
      cnt    <= '0;
      last   <= '0;
    end
    else if (start_i)
    begin
      busy_o <= 1'b1;
      cnt    <= '0;
      last   <= pdmc_settle_cycles(sel_i, BASE_STATES) - PDMC_CNT_W'(1);
    end
    else if (done_o)
    begin
      busy_o <= 1'b0;
    end
    else if (busy_o)
    begin
      cnt <= cnt + PDMC_CNT_W'(1);
    end
  end
endmodule : pdmc_settle_counter

//--- logic/pdmc_top.sv
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ps
module pdmc_top
  import pdmc_pkg::*;
#(
  parameter int BASE_STATES = PDMC_BASE_STATES
)
(
  input  wire logic                   CLK_I,
  input  wire logic                   RST_N_I,
  input  wire logic [PDMC_AXI_AW-1:0] S_AXI_AWADDR_I,
  input  wire logic                   S_AXI_AWVALID_I,
  output logic                        S_AXI_AWREADY_O,
  input  wire logic [31:0]            S_AXI_WDATA_I,
  input  wire logic [3:0]             S_AXI_WSTRB_I,
  input  wire logic                   S_AXI_WVALID_I,
  output logic                        S_AXI_WREADY_O,
  output logic [1:0]                  S_AXI_BRESP_O,
  output logic                        S_AXI_BVALID_O,
  input  wire logic                   S_AXI_BREADY_I,
  input  wire logic [PDMC_AXI_AW-1:0] S_AXI_ARADDR_I,
  input  wire logic                   S_AXI_ARVALID_I,
  output logic                        S_AXI_ARREADY_O,
  output logic [31:0]                 S_AXI_RDATA_O,
  output logic [1:0]                  S_AXI_RRESP_O,
  output logic                        S_AXI_RVALID_O,
  input  wire logic                   S_AXI_RREADY_I,
  input  wire logic                   HALT_EXEC_I,
  input  wire logic                   INT_MASK_I,
  input  wire logic                   MOD_IRQ_I,
  input  wire logic                   NMI_N_I,
  input  wire logic [2:0]             EXT_INT_LINES_N_I,
  input  wire logic                   HW_STANDBY_PIN_N_I,
  input  wire logic                   CHIP_CLEAR_N_I,
  output logic                        CPU_CLK_EN_O,
  output logic                        MOD_CLK_EN_O,
  output logic                        OSC_EN_O,
  output logic                        MOD_INIT_O,
  output logic                        CPU_REG_CLEAR_O,
  output logic                        PORT_HIZ_O,
  output logic                        RESET_SEQ_O,
  output logic                        IRQ_SEQ_O
);
  pdmc_state_t      state;
  pdmc_state_t      next_state;
  logic [5:0]       pins_s;
  logic             nmi_n_s;
  logic [2:0]       ext_n_s;
  logic             hw_n_s;
  logic             clr_n_s;
  logic             standby_select;
  logic [2:0]       settling_time_select;
  logic [2:0]       low_bits;
  logic             mask_at_halt;
  logic             settle_busy;
  logic             settle_done;
  logic [7:0]       sysctl_rd;
  logic             aw_held;
  logic             w_held;
  logic [15:0]      aw_addr;
  logic [31:0]      w_data;
  logic [3:0]       w_strb;
  logic             do_write;
  logic             wr_mapped;
  logic             wr_sysctl;
  logic             rd_take;
  logic             rd_sysctl;
  logic             rd_status;
  logic             irq_any;
  logic             wake_sleep;
  logic             wake_ext;
  logic             settle_start;

  // Pins from the board pass two flops; CPU-side strobes share the clock
  pdmc_pin_sync #(
    .W    (PDMC_PIN_W),
    .INIT (PDMC_PIN_IDLE)
  ) u_sync (
    .clk_i   (CLK_I),
    .rst_n_i (RST_N_I),
    .pin_i   ({NMI_N_I, EXT_INT_LINES_N_I, HW_STANDBY_PIN_N_I, CHIP_CLEAR_N_I}),
    .sync_o  (pins_s)
  );

  assign nmi_n_s = pins_s[5];
  assign ext_n_s = pins_s[4:2];
  assign hw_n_s  = pins_s[1];
  assign clr_n_s = pins_s[0];

  // Register bus slave
  assign S_AXI_AWREADY_O = !aw_held && !S_AXI_BVALID_O;
  assign S_AXI_WREADY_O  = !w_held && !S_AXI_BVALID_O;
  assign S_AXI_ARREADY_O = !S_AXI_RVALID_O;
  assign do_write  = aw_held && w_held && !S_AXI_BVALID_O;
  assign wr_mapped = (aw_addr == PDMC_SYSCTL_ADDR) || (aw_addr == PDMC_STATUS_ADDR);
  assign wr_sysctl = do_write && (aw_addr == PDMC_SYSCTL_ADDR) && w_strb[0];
  assign rd_take   = S_AXI_ARVALID_I && S_AXI_ARREADY_O;
  assign rd_sysctl = S_AXI_ARADDR_I == PDMC_SYSCTL_ADDR;
  assign rd_status = S_AXI_ARADDR_I == PDMC_STATUS_ADDR;
  assign sysctl_rd = {standby_select, settling_time_select, 1'b1, low_bits};

  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
    begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= '0;
      w_data  <= '0;
      w_strb  <= '0;
    end
    else
    begin
      if (S_AXI_AWVALID_I && S_AXI_AWREADY_O)
      begin
        aw_held <= 1'b1;
        aw_addr <= S_AXI_AWADDR_I;
      end
      else if (do_write)
      begin
        aw_held <= 1'b0;
      end
      if (S_AXI_WVALID_I && S_AXI_WREADY_O)
      begin
        w_held <= 1'b1;
        w_data <= S_AXI_WDATA_I;
        w_strb <= S_AXI_WSTRB_I;
      end
      else if (do_write)
      begin
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
    begin
      S_AXI_BVALID_O <= 1'b0;
      S_AXI_BRESP_O  <= PDMC_RESP_OKAY;
      S_AXI_RVALID_O <= 1'b0;
      S_AXI_RRESP_O  <= PDMC_RESP_OKAY;
      S_AXI_RDATA_O  <= '0;
    end
    else
    begin
      if (do_write)
      begin
        S_AXI_BVALID_O <= 1'b1;
        S_AXI_BRESP_O  <= wr_mapped ? PDMC_RESP_OKAY : PDMC_RESP_DECERR;
      end
      else if (S_AXI_BREADY_I)
      begin
        S_AXI_BVALID_O <= 1'b0;
      end
      if (rd_take)
      begin
        S_AXI_RVALID_O <= 1'b1;
        S_AXI_RRESP_O  <= (rd_sysctl || rd_status) ? PDMC_RESP_OKAY : PDMC_RESP_DECERR;
        S_AXI_RDATA_O  <= rd_sysctl ? {24'h0, sysctl_rd} :
                          rd_status ? {25'h0, settle_busy, state} : 32'h0;
      end
      else if (S_AXI_RREADY_I)
      begin
        S_AXI_RVALID_O <= 1'b0;
      end
    end
  end

  // Chip clear reloads the whole register, so the select bit drops to 0
  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I || !clr_n_s)
    begin
      standby_select       <= PDMC_SYSCTL_RESET[PDMC_STANDBY_SELECT_BIT_BIT];
      settling_time_select <= PDMC_SYSCTL_RESET[PDMC_STS_MSB:PDMC_STS_LSB];
      low_bits             <= PDMC_SYSCTL_RESET[PDMC_LOW_MSB:0];
    end
    else if (wr_sysctl)
    begin
      standby_select       <= w_data[PDMC_STANDBY_SELECT_BIT_BIT];
      settling_time_select <= w_data[PDMC_STS_MSB:PDMC_STS_LSB];
      low_bits             <= w_data[PDMC_LOW_MSB:0];
    end
  end

  // Power-down sequencer
  assign irq_any    = MOD_IRQ_I || !(&ext_n_s);
  assign wake_sleep = !nmi_n_s || (irq_any && !mask_at_halt);
  assign wake_ext   = !nmi_n_s || !(&ext_n_s);
  assign settle_start = (state == PDMC_SWSTBY) && (next_state == PDMC_SETTLE);

  always_comb
  begin
    next_state = state;
    if (!hw_n_s)
    begin
      next_state = PDMC_HWSTBY;
    end
    else if (!clr_n_s)
    begin
      next_state = PDMC_CLEAR;
    end
    else
    begin
      case (state)
        PDMC_RUN:
        begin
          if (HALT_EXEC_I)
          begin
            next_state = standby_select ? PDMC_SWSTBY : PDMC_SLEEP;
          end
        end
        PDMC_SLEEP:
        begin
          if (wake_sleep)
          begin
            next_state = PDMC_RUN;
          end
        end
        PDMC_SWSTBY:
        begin
          if (wake_ext)
          begin
            next_state = PDMC_SETTLE;
          end
        end
        PDMC_SETTLE:
        begin
          if (settle_done)
          begin
            next_state = PDMC_RUN;
          end
        end
        PDMC_CLEAR:
        begin
          next_state = PDMC_RUN;
        end
        default:
        begin
          // Standby released with clear high: wait for a clear pulse
          next_state = state;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
    begin
      state        <= PDMC_RUN;
      mask_at_halt <= 1'b0;
      RESET_SEQ_O  <= 1'b0;
      IRQ_SEQ_O    <= 1'b0;
    end
    else
    begin
      state       <= next_state;
      RESET_SEQ_O <= (state == PDMC_CLEAR) && (next_state == PDMC_RUN);
      IRQ_SEQ_O   <= (state == PDMC_SLEEP || state == PDMC_SETTLE) &&
                     (next_state == PDMC_RUN);
      if (state == PDMC_RUN && HALT_EXEC_I)
      begin
        mask_at_halt <= INT_MASK_I;
      end
    end
  end

  pdmc_settle_counter #(
    .BASE_STATES (BASE_STATES)
  ) u_settle (
    .clk_i   (CLK_I),
    .rst_n_i (RST_N_I),
    .start_i (settle_start),
    .abort_i (state != PDMC_SETTLE && !settle_start),
    .sel_i   (settling_time_select),
    .busy_o  (settle_busy),
    .done_o  (settle_done)
  );

  assign CPU_CLK_EN_O    = state == PDMC_RUN;
  assign MOD_CLK_EN_O    = state == PDMC_RUN || state == PDMC_SLEEP;
  assign OSC_EN_O        = state != PDMC_SWSTBY && state != PDMC_HWSTBY;
  assign MOD_INIT_O      = state == PDMC_SWSTBY || state == PDMC_HWSTBY;
  assign CPU_REG_CLEAR_O = state == PDMC_HWSTBY;
  assign PORT_HIZ_O      = state == PDMC_HWSTBY;

  // Checks
  logic [PDMC_CNT_W-1:0] settle_seen;
  logic [2:0]            settle_sel;

  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I || state != PDMC_SETTLE)
    begin
      settle_seen <= '0;
    end
    else
    begin
      settle_seen <= settle_seen + PDMC_CNT_W'(1);
    end
  end

  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
    begin
      settle_sel <= '0;
    end
    else if (settle_start)
    begin
      settle_sel <= settling_time_select;
    end
  end

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);

  sequence s_pins_quiet;
    hw_n_s && clr_n_s;
  endsequence

  sequence s_settle_exit;
    state == PDMC_SETTLE && settle_done && hw_n_s && clr_n_s;
  endsequence

  a_sleep_entry: assert property ((state == PDMC_RUN && HALT_EXEC_I && !standby_select)
    and s_pins_quiet |=> state == PDMC_SLEEP && !CPU_CLK_EN_O && MOD_CLK_EN_O)
    else $error("halt with select 0 did not enter sleep");
  a_swstby_entry: assert property ((state == PDMC_RUN && HALT_EXEC_I && standby_select)
    and s_pins_quiet |=> state == PDMC_SWSTBY)
    else $error("halt with select 1 did not enter software standby");
  a_sleep_outputs: assert property (state == PDMC_SLEEP |->
    OSC_EN_O && MOD_CLK_EN_O && !CPU_CLK_EN_O && !MOD_INIT_O)
    else $error("sleep outputs wrong");
  a_swstby_outputs: assert property (state == PDMC_SWSTBY |->
    !OSC_EN_O && !CPU_CLK_EN_O && !MOD_CLK_EN_O && MOD_INIT_O && !PORT_HIZ_O)
    else $error("software standby outputs wrong");
  a_hw_priority: assert property (!hw_n_s |=> state == PDMC_HWSTBY && PORT_HIZ_O
    && CPU_REG_CLEAR_O && !OSC_EN_O)
    else $error("standby pin low did not force hardware standby");
  a_mask_sleep: assert property ((state == PDMC_SLEEP && mask_at_halt && nmi_n_s)
    and s_pins_quiet |=> state == PDMC_SLEEP)
    else $error("masked sleep woke without nonmaskable interrupt");
  a_ext_wake: assert property ((state == PDMC_SWSTBY && !(&ext_n_s)) and s_pins_quiet
    |=> state == PDMC_SETTLE ##1 settle_busy && OSC_EN_O)
    else $error("external interrupt did not start settling");
  a_settle_gate: assert property (state == PDMC_SETTLE |->
    OSC_EN_O && !CPU_CLK_EN_O && !MOD_CLK_EN_O)
    else $error("clocks leaked during settling");
  a_settle_len: assert property (s_settle_exit |->
    settle_seen == pdmc_settle_cycles(settle_sel, BASE_STATES) - PDMC_CNT_W'(1))
    else $error("settling wait has wrong length");
  a_standby_select_bit_kept: assert property (s_settle_exit ##0 (standby_select && !wr_sysctl) |=>
    state == PDMC_RUN && standby_select && IRQ_SEQ_O)
    else $error("select bit lost after interrupt recovery");
  a_clear_exit: assert property (hw_n_s && !clr_n_s ##1 hw_n_s && clr_n_s && !wr_sysctl
    |=> state == PDMC_RUN && !standby_select && RESET_SEQ_O)
    else $error("chip clear recovery wrong");
endmodule : pdmc_top

//--- testbench/pdmc_pin_model.sv
`timescale 1ns/1ps
module pdmc_pin_model
(
  input  wire logic       clk_i,
  input  wire logic       slow_i,
  input  wire logic       nmi_req_i,
  input  wire logic [2:0] ext_req_i,
  input  wire logic       hw_standby_pin_n_req_i,
  input  wire logic       clr_req_i,
  output logic            nmi_n_o,
  output logic [2:0]      ext_n_o,
  output logic            hw_standby_pin_n_n_o,
  output logic            clr_n_o
);
  // Slow mode holds each pin edge back four cycles, like a lazy board driver
  logic [5:0]  req;
  logic [23:0] pipe;
  logic [5:0]  sel;
  assign req = {clr_req_i, hw_standby_pin_n_req_i, ext_req_i, nmi_req_i};
  assign sel = slow_i ? pipe[23:18] : req;
  always_ff @(posedge clk_i)
  begin
    pipe <= {pipe[17:0], req};
  end
  assign {clr_n_o, hw_standby_pin_n_n_o, ext_n_o, nmi_n_o} = ~sel;
endmodule : pdmc_pin_model

//--- testbench/pdmc_top_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, s) begin if ((s) !== (e)) begin \
  $display("Error %s exp %0h seen %0h", nm, e, s); n_mismatch++; end tests_run++; end
module pdmc_top_tb
  import pdmc_pkg::*;
;
  logic        clk, rst_n, awv, wv, bready, arv, rready, halt, imask, mirq;
  logic        nmi_rq, hw_standby_pin_n_rq, clr_rq, slow, awrdy, wrdy, bvalid, arrdy, rvalid;
  logic        cpu_en, mod_en, osc, init, regclr, hiz, rseq, iseq, nmi_n, hw_standby_pin_n_n, clr_n;
  logic [2:0]  ext_rq, ext_n;
  logic [15:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [1:0]  bresp, rresp, rs, br;
  int          n_mismatch, tests_run, cyc, n_irq, n_rst, n;
  pdmc_top #(.BASE_STATES(8)) u_pdmc_top (.CLK_I(clk), .RST_N_I(rst_n),
    .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awrdy),
    .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wv),
    .S_AXI_WREADY_O(wrdy), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid),
    .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arv),
    .S_AXI_ARREADY_O(arrdy), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp),
    .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready), .HALT_EXEC_I(halt),
    .INT_MASK_I(imask), .MOD_IRQ_I(mirq), .NMI_N_I(nmi_n), .EXT_INT_LINES_N_I(ext_n),
    .HW_STANDBY_PIN_N_I(hw_standby_pin_n_n), .CHIP_CLEAR_N_I(clr_n), .CPU_CLK_EN_O(cpu_en),
    .MOD_CLK_EN_O(mod_en), .OSC_EN_O(osc), .MOD_INIT_O(init), .CPU_REG_CLEAR_O(regclr),
    .PORT_HIZ_O(hiz), .RESET_SEQ_O(rseq), .IRQ_SEQ_O(iseq));
  pdmc_pin_model u_pdmc_pin_model (.clk_i(clk), .slow_i(slow), .nmi_req_i(nmi_rq),
    .ext_req_i(ext_rq), .hw_standby_pin_n_req_i(hw_standby_pin_n_rq), .clr_req_i(clr_rq), .nmi_n_o(nmi_n),
    .ext_n_o(ext_n), .hw_standby_pin_n_n_o(hw_standby_pin_n_n), .clr_n_o(clr_n));
  initial
  begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  task automatic wrap_up();
    if (n_mismatch == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  // Longest path is five waits of at most 128 cycles, so this ceiling is generous
  always @(posedge clk)
  begin
    cyc++;
    if (iseq === 1'b1) n_irq++;
    if (rseq === 1'b1) n_rst++;
    if (cyc > 20000)
    begin
      n_mismatch++;
      wrap_up();
    end
  end
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : step
  task automatic axi_wr(input logic [15:0] a, input logic [31:0] v);
    logic ga, gw;
    ga = 0;
    gw = 0;
    @(posedge clk);
    awaddr <= a; wdata <= v; awv <= 1; wv <= 1; bready <= 1;
    while (!(ga && gw))
    begin
      @(posedge clk);
      ga = ga | awrdy;
      gw = gw | wrdy;
      if (ga) awv <= 0;
      if (gw) wv <= 0;
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    br = bresp;
    bready <= 0;
  endtask : axi_wr
  task automatic axi_rd(input logic [15:0] a, output logic [31:0] v, output logic [1:0] r);
    @(posedge clk);
    araddr <= a; arv <= 1; rready <= 1;
    do @(posedge clk); while (arrdy !== 1'b1);
    arv <= 0;
    do @(posedge clk); while (rvalid !== 1'b1);
    v = rdata;
    r = rresp;
    rready <= 0;
  endtask : axi_rd
  task automatic halt_op(input logic m);
    @(posedge clk);
    halt <= 1; imask <= m;
    @(posedge clk);
    halt <= 0;
    step(1);
  endtask : halt_op
  initial
  begin
    rst_n = 0; awv = 0; wv = 0; bready = 0; arv = 0; rready = 0; halt = 0; imask = 0;
    mirq = 0; nmi_rq = 0; hw_standby_pin_n_rq = 0; clr_rq = 0; slow = 0; ext_rq = 3'h0;
    awaddr = 16'h0000; araddr = 16'h0000; wdata = 32'h0;
    repeat (3) @(posedge clk);
    rst_n <= 1;
    axi_rd(PDMC_SYSCTL_ADDR, d, rs);
    `CHK("sysctl reset", 32'h09, d)
    axi_rd(PDMC_STATUS_ADDR, d, rs);
    `CHK("state run", 32'h01, d)
    axi_rd(16'h0010, d, rs);
    `CHK("unmapped resp", PDMC_RESP_DECERR, rs)
    `CHK("unmapped data", 32'h0, d)
    axi_wr(16'h0010, 32'hff);
    `CHK("unmapped wr resp", PDMC_RESP_DECERR, br)
    axi_wr(PDMC_SYSCTL_ADDR, 32'h00);
    `CHK("write resp", PDMC_RESP_OKAY, br)
    halt_op(0);
    `CHK("sleep clocks", 3'b011, {cpu_en, mod_en, osc})
    axi_rd(PDMC_STATUS_ADDR, d, rs);
    `CHK("state sleep", 32'h02, d)
    @(posedge clk) mirq <= 1;
    step(3);
    @(posedge clk) mirq <= 0;
    step(1);
    `CHK("sleep wake", 1'b1, cpu_en)
    halt_op(1);
    @(posedge clk) mirq <= 1;
    step(6);
    axi_rd(PDMC_STATUS_ADDR, d, rs);
    `CHK("masked sleep", 32'h02, d)
    @(posedge clk) begin mirq <= 0; nmi_rq <= 1; end
    step(6);
    @(posedge clk) begin nmi_rq <= 0; imask <= 0; end
    step(2);
    `CHK("nmi wake", 1'b1, cpu_en)
    `CHK("irq seq count", 2, n_irq)
    for (int s = 0; s < 5; s++)
    begin
      axi_wr(PDMC_SYSCTL_ADDR, {24'h0, 1'b1, 3'(s), 4'h1});
      @(posedge clk) slow <= s[0];
      halt_op(0);
      `CHK("swstby outputs", 4'b0001, {cpu_en, mod_en, osc, init})
      @(posedge clk) mirq <= 1;
      step(4);
      `CHK("swstby no mod wake", 1'b0, osc)
      @(posedge clk) begin mirq <= 0; ext_rq[s % 3] <= 1; end
      n = 0;
      while (osc !== 1'b1 && n < 50) begin step(1); n++; end
      `CHK("settle gated", 2'b00, {cpu_en, mod_en})
      n = 0;
      while (cpu_en !== 1'b1 && n < 300) begin step(1); n++; end
      `CHK("settle length", (s > 3) ? 128 : (8 << s), n)
      @(posedge clk) ext_rq <= 3'h0;
      axi_rd(PDMC_SYSCTL_ADDR, d, rs);
      `CHK("select kept", {24'h0, 1'b1, 3'(s), 4'h9}, d)
    end
    @(posedge clk) slow <= 0;
    step(2);
    `CHK("irq seq after settle", 7, n_irq)
    axi_wr(PDMC_SYSCTL_ADDR, 32'h01);
    halt_op(0);
    @(posedge clk) hw_standby_pin_n_rq <= 1;
    step(5);
    `CHK("hw standby outs", 6'b000111, {cpu_en, mod_en, osc, init, regclr, hiz})
    @(posedge clk) hw_standby_pin_n_rq <= 0;
    step(5);
    axi_rd(PDMC_STATUS_ADDR, d, rs);
    `CHK("hw standby held", 32'h10, d)
    @(posedge clk) clr_rq <= 1;
    step(5);
    @(posedge clk) clr_rq <= 0;
    step(5);
    `CHK("reset seq", 1, n_rst)
    axi_wr(PDMC_SYSCTL_ADDR, 32'h81);
    halt_op(0);
    @(posedge clk) clr_rq <= 1;
    step(5);
    @(posedge clk) clr_rq <= 0;
    step(5);
    axi_rd(PDMC_SYSCTL_ADDR, d, rs);
    `CHK("clear reload", 32'h09, d)
    `CHK("reset seq 2", 2, n_rst)
    wrap_up();
  end
endmodule : pdmc_top_tb
